// ===== hdl/rtm_pkg.sv
// Purpose: shared constants for the register transfer and modification unit
// Assumes: 16-bit data words, one-word instructions
// Notes:   field positions and codes of the instruction word
`default_nettype none
package rtm_pkg;
   localparam int          WORD_W        = 16;
   localparam logic [6:0]  GROUP_CODE    = 7'h05;   // bits 15..9 = 0 000101
   localparam int          GROUP_LSB     = 9;
   localparam int          COND_BIT      = 8;
   localparam int          OP_LSB        = 6;
   localparam int          SRC_LSB       = 3;
   localparam int          DST_LSB       = 0;
   localparam logic [15:0] SWITCH_LOAD   = 16'h0F02; // octal 007402
   localparam logic [15:0] MAX_POSITIVE  = 16'h7FFF; // octal 077777
   localparam logic [15:0] MAX_NEGATIVE  = 16'h8000; // octal 0100000
   localparam logic [15:0] RESET_WORD    = 16'h0000;

   typedef enum logic [1:0] {
      OP_PLAIN  = 2'h0,
      OP_ADD    = 2'h1,
      OP_INVERT = 2'h2,
      OP_SUB    = 2'h3
   } op_t;
endpackage
`default_nettype wire

// ===== hdl/operand_bus_if.sv
// Purpose: carries the merged operand and result between top and modifier
// Assumes: single clock, purely combinational traffic
// Notes:   modifier computes, top consumes
`default_nettype none
interface operand_bus_if;
   import rtm_pkg::*;
   logic [15:0] operand;
   op_t         op;
   logic [15:0] result;
   logic        wrap;
   modport top  (output operand, output op, input result, input wrap);
   modport calc (input operand, input op, output result, output wrap);
endinterface
`default_nettype wire

// ===== hdl/source_merge.sv
// Purpose: ORs the selected source registers, in any combination, into one operand
// Assumes: selection bits may be any combination
// Notes:   no bit set gives a zero operand
`default_nettype none
module source_merge
   import rtm_pkg::*;
(
   input  wire logic [2:0]  select,
   input  wire logic [15:0] acc,
   input  wire logic [15:0] sec,
   input  wire logic [15:0] idx,
   output logic      [15:0] merged
);
   // ==========================================================
   // operand merge
   function automatic logic [15:0] gate(input logic en, input logic [15:0] v);
      return en ? v : 16'h0000;
   endfunction

   // inclusive or of every selected register, zero when none chosen
   assign merged = gate(select[0], acc) | gate(select[1], sec) | gate(select[2], idx);
endmodule
`default_nettype wire

// ===== hdl/operand_modifier.sv
// Purpose: applies add one, subtract one, invert or pass to the operand
// Assumes: bit 15 is the sign
// Notes:   wrap flags the sign overflow of add and subtract only
`default_nettype none
module operand_modifier
   import rtm_pkg::*;
(
   operand_bus_if.calc bus
);
   // ==========================================================
   // modification
   always_comb begin
      bus.wrap = 1'b0;
      case (bus.op)
         OP_PLAIN:  bus.result = bus.operand;
         OP_ADD: begin
            bus.result = bus.operand + 16'h0001;
            bus.wrap   = (bus.operand == MAX_POSITIVE);
         end
         OP_INVERT: bus.result = ~bus.operand;
         OP_SUB: begin
            bus.result = bus.operand - 16'h0001;
            bus.wrap   = (bus.operand == MAX_NEGATIVE);
         end
         default:   bus.result = bus.operand;
      endcase
   end
endmodule
`default_nettype wire

// ===== hdl/register_transfer_modify_unit.sv
// Purpose: executes the register transfer and modification instruction group
// Assumes: one instruction per exec_strobe, synchronous inputs
// Notes:   results land one edge after the strobe
//          the decoder may issue a word on every cycle; each word sees the registers
//          as they stood before its own edge, so a register named as both source and
//          destination is read old and written new in one step
//          the switch load word is decoded apart from the group because its upper
//          bits fall outside the group code
//          overflow_clear is a local port so that software has a way to drop the flag;
//          when a wrap and a clear meet in one cycle the wrap wins, so no overflow
//          is ever lost between a test and a clear
//          the conditional forms never move the flag, even when they wrap themselves
//          group_hit is combinational and only valid while exec_strobe is high
//          executed is a one-cycle registered pulse, low for skipped conditional words
//          limitation: words outside the group are ignored without any indication
//          other than group_hit staying low
//          the checks at the foot of this file restate the rules from the outside,
//          using the merged operand rather than the modifier's outputs, except sign_wrap_a, which reads bus.result, and flag_clear_a, which reads bus.wrap
`default_nettype none
module register_transfer_modify_unit
   import rtm_pkg::*;
#(
   parameter int WIDTH = WORD_W
)
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        exec_strobe,
   input  wire logic [15:0] instr_word,
   input  wire logic [15:0] entry_switches,
   input  wire logic        overflow_clear,
   output logic      [15:0] acc,
   output logic      [15:0] secondary_acc,
   output logic      [15:0] index_reg,
   output logic             overflow_flag,
   output logic             group_hit,
   output logic             executed
);
   // ==========================================================
   // decode
   logic        is_group;
   logic        is_switch_load;
   logic        cond_ok;
   logic        do_exec;
   logic [2:0]  src_sel;
   logic [2:0]  dst_sel;
   logic [15:0] merged;
   logic [15:0] next_acc;
   logic [15:0] next_sec;
   logic [15:0] next_idx;
   logic        next_overflow;
   logic        next_executed;

   operand_bus_if bus ();

   // switch load lies outside the group code, so it is decoded on its own and takes precedence
   assign is_switch_load = (instr_word == SWITCH_LOAD);
   assign is_group       = (instr_word[15:GROUP_LSB] == GROUP_CODE);
   assign src_sel        = instr_word[SRC_LSB +: 3];
   assign dst_sel        = instr_word[DST_LSB +: 3];
   assign cond_ok        = !instr_word[COND_BIT] || overflow_flag;
   assign do_exec        = exec_strobe && is_group && cond_ok;
   assign group_hit      = exec_strobe && (is_group || is_switch_load);

   // ==========================================================
   // datapath
   // merge uses the registered values, so old contents feed the sum
   source_merge merge_u (
      .select (src_sel),
      .acc    (acc),
      .sec    (secondary_acc),
      .idx    (index_reg),
      .merged (merged)
   );

   assign bus.operand = merged;
   assign bus.op      = op_t'(instr_word[OP_LSB +: 2]);

   // sixteen-bit modifier; bit 15 is the sign for the wrap test
   operand_modifier mod_u (
      .bus (bus)
   );

   // ==========================================================
   // next state
   always_comb begin
      next_acc      = acc;
      next_sec      = secondary_acc;
      next_idx      = index_reg;
      next_overflow = overflow_flag;
      next_executed = 1'b0;
      if (overflow_clear) begin
         next_overflow = 1'b0;
      end
      if (exec_strobe && is_switch_load) begin
         next_acc      = entry_switches;
         next_executed = 1'b1;
      end else if (do_exec) begin
         next_executed = 1'b1;
         // same result into every chosen register, e.g. 011 or 110
         if (dst_sel[0]) begin
            next_acc = bus.result;
         end
         if (dst_sel[1]) begin
            next_sec = bus.result;
         end
         if (dst_sel[2]) begin
            next_idx = bus.result;
         end
         // conditional forms keep the flag; invert and plain never touch it
         if (bus.wrap && !instr_word[COND_BIT]) begin
            next_overflow = 1'b1;
         end
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         acc           <= RESET_WORD;
         secondary_acc <= RESET_WORD;
         index_reg     <= RESET_WORD;
         overflow_flag <= 1'b0;
         executed      <= 1'b0;
      end else begin
         acc           <= next_acc;
         secondary_acc <= next_sec;
         index_reg     <= next_idx;
         overflow_flag <= next_overflow;
         executed      <= next_executed;
      end
   end

   // ==========================================================
   // checks
   logic [1:0] op_f;
   assign op_f = instr_word[OP_LSB +: 2];

   add_wrap_a: assert property (@(posedge sys_clk) disable iff (rst)
      (do_exec && !is_switch_load && op_f == 2'h1 && dst_sel[0] && merged == MAX_POSITIVE
       && !instr_word[COND_BIT]) |=> (acc == MAX_NEGATIVE && overflow_flag))
      else $error("increment wrap wrong");

   sub_wrap_a: assert property (@(posedge sys_clk) disable iff (rst)
      (do_exec && !is_switch_load && op_f == 2'h3 && dst_sel[1] && merged == MAX_NEGATIVE
       && !instr_word[COND_BIT]) |=> (secondary_acc == MAX_POSITIVE && overflow_flag))
      else $error("decrement wrap wrong");

   invert_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
      (do_exec && op_f == 2'h2 && !overflow_clear) |=> $stable(overflow_flag))
      else $error("invert changed overflow");

   cond_skip_a: assert property (@(posedge sys_clk) disable iff (rst)
      (exec_strobe && is_group && !is_switch_load && instr_word[COND_BIT] && !overflow_flag)
      |=> ($stable(acc) && $stable(secondary_acc) && $stable(index_reg)))
      else $error("conditional ran without overflow");

   cond_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
      (do_exec && instr_word[COND_BIT] && !overflow_clear) |=> overflow_flag)
      else $error("conditional form altered overflow");

   switch_load_a: assert property (@(posedge sys_clk) disable iff (rst)
      (exec_strobe && is_switch_load) |=> (acc == $past(entry_switches)))
      else $error("switch load wrong");

   merge_or_a: assert property (@(posedge sys_clk) disable iff (rst)
      (do_exec && !is_switch_load && op_f == 2'h0 && dst_sel == 3'h4)
      |=> (index_reg == (($past(src_sel[0]) ? $past(acc) : 16'h0000)
                      | ($past(src_sel[1]) ? $past(secondary_acc) : 16'h0000)
                      | ($past(src_sel[2]) ? $past(index_reg) : 16'h0000))))
      else $error("merged operand wrong");

   no_dest_a: assert property (@(posedge sys_clk) disable iff (rst)
      (do_exec && !is_switch_load && dst_sel == 3'h0)
      |=> ($stable(acc) && $stable(secondary_acc) && $stable(index_reg)))
      else $error("null destination wrote");

   dual_dest_a: assert property (@(posedge sys_clk) disable iff (rst)
      (do_exec && !is_switch_load && dst_sel == 3'h3) |=> (acc == secondary_acc))
      else $error("dual destination mismatch");

   // both upper registers get one result when 110 is chosen
   multi_dest_a: assert property (@(posedge sys_clk) disable iff (rst)
      (do_exec && dst_sel == 3'h6) |=> (index_reg == secondary_acc))
      else $error("multi destination mismatch");

   // a plain copy must arrive bit for bit
   plain_copy_a: assert property (@(posedge sys_clk) disable iff (rst)
      (do_exec && op_f == 2'h0 && dst_sel == 3'h2) |=> (secondary_acc == $past(merged)))
      else $error("plain transfer altered data");

   // a plain transfer from an empty source field clears what it writes
   zero_source_a: assert property (@(posedge sys_clk) disable iff (rst)
      (do_exec && op_f == 2'h0 && src_sel == 3'h0 && dst_sel[2]) |=> (index_reg == 16'h0000))
      else $error("zero source did not clear");

   // invert works on the merged operand, not on the old destination
   invert_value_a: assert property (@(posedge sys_clk) disable iff (rst)
      (do_exec && op_f == 2'h2 && dst_sel[0]) |=> (acc == ~$past(merged)))
      else $error("invert value wrong");

   // add one applied after the merge
   add_value_a: assert property (@(posedge sys_clk) disable iff (rst)
      (do_exec && op_f == 2'h1 && dst_sel[2]) |=> (index_reg == $past(merged) + 16'h0001))
      else $error("increment value wrong");

   // subtract one applied after the merge
   sub_value_a: assert property (@(posedge sys_clk) disable iff (rst)
      (do_exec && op_f == 2'h3 && dst_sel[0]) |=> (acc == $past(merged) - 16'h0001))
      else $error("decrement value wrong");

   // conditional subtract leaves the flag standing
   cond_sub_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
      (do_exec && instr_word[COND_BIT] && op_f == 2'h3 && !overflow_clear) |=> overflow_flag)
      else $error("conditional subtract altered overflow");

   // sign change from plus to minus on add is an overflow
   sign_wrap_a: assert property (@(posedge sys_clk) disable iff (rst)
      (do_exec && op_f == 2'h1 && !instr_word[COND_BIT] && !merged[15] && bus.result[15])
      |=> overflow_flag)
      else $error("sign overflow missed");

   // words outside the group leave every register alone
   outside_group_a: assert property (@(posedge sys_clk) disable iff (rst)
      (exec_strobe && !is_group && !is_switch_load)
      |=> (!executed && $stable(acc) && $stable(secondary_acc) && $stable(index_reg)))
      else $error("foreign word changed state");

   // every word that runs raises executed once
   exec_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
      (do_exec || (exec_strobe && is_switch_load)) |=> executed)
      else $error("executed pulse missing");

   // a clear with no wrap in the same cycle drops the flag
   flag_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
      (overflow_clear && !(do_exec && bus.wrap && !instr_word[COND_BIT])) |=> !overflow_flag)
      else $error("overflow clear ignored");
endmodule
`default_nettype wire

// ===== verification/seq_model.sv
// Purpose: stand-in for the decoder and sequencer that issues words
// Assumes: called from the falling edge of sys_clk
// Notes:   an idle word shows the inverse of the last one
`default_nettype none
module seq_model (
   output logic        exec_strobe,
   output logic [15:0] instr_word
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // issue one word, or idle
   // scrambling the idle word shows up a design that samples late
   task automatic issue(input logic [15:0] w, input logic en);
      exec_strobe = en;
      instr_word  = en ? w : ~instr_word;
   endtask
   initial begin
      exec_strobe = 1'b0;
      instr_word  = 16'h0000;
   end
endmodule
`default_nettype wire

// ===== verification/tb_register_transfer_modify_unit.sv
// Purpose: self-checking bench for the transfer and modify unit
// Assumes: inputs change on the falling edge, results one edge later
// Notes:   corner words first, then lfsr words
`default_nettype none
module tb_register_transfer_modify_unit;
   import rtm_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        sys_clk, rst, exec_strobe, overflow_clear, overflow_flag;
   logic        group_hit, executed, mof, mexe;
   logic [15:0] instr_word, entry_switches, acc, secondary_acc, index_reg;
   logic [15:0] ma, mb, mx, w;
   logic [31:0] seed;
   logic [47:0] corners [12];
   int          bad_count, compares;
   register_transfer_modify_unit #(.WIDTH(WORD_W)) register_transfer_modify_unit_inst (
      .sys_clk(sys_clk), .rst(rst), .exec_strobe(exec_strobe), .instr_word(instr_word),
      .entry_switches(entry_switches), .overflow_clear(overflow_clear), .acc(acc),
      .secondary_acc(secondary_acc), .index_reg(index_reg), .overflow_flag(overflow_flag),
      .group_hit(group_hit), .executed(executed));
   seq_model seq_model_inst (.exec_strobe(exec_strobe), .instr_word(instr_word));
   // ==========================================
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // wrap bit on top of the 16-bit result
   function automatic logic [16:0] modify(input logic [15:0] v, input logic [1:0] op);
      case (op)
         2'h1: return {v == MAX_POSITIVE, v + 16'h0001};
         2'h3: return {v == MAX_NEGATIVE, v - 16'h0001};
         2'h2: return {1'b0, ~v};
         default: return {1'b0, v};
      endcase
   endfunction
   task automatic check(input string name, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", name, e, g);
      end
   endtask
   task automatic tally_and_finish();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // compare last results, drive a word, advance the model
   task automatic step(input logic [15:0] wd, input logic en, input logic clr,
                       input logic [15:0] sw);
      logic [15:0] opnd;
      logic [16:0] res;
      logic        run, ld;
      check("acc", ma, acc);
      check("secondary_acc", mb, secondary_acc);
      check("index_reg", mx, index_reg);
      check("overflow_flag", {15'h0, mof}, {15'h0, overflow_flag});
      check("executed", {15'h0, mexe}, {15'h0, executed});
      entry_switches = sw;
      overflow_clear = clr;
      seq_model_inst.issue(wd, en);
      ld  = en && wd == SWITCH_LOAD;
      run = en && wd[15:9] == GROUP_CODE && (!wd[8] || mof);
      #1 check("group_hit", {15'h0, en && (wd[15:9] == GROUP_CODE || ld)}, {15'h0, group_hit});
      opnd = (wd[3] ? ma : 16'h0000) | (wd[4] ? mb : 16'h0000) | (wd[5] ? mx : 16'h0000);
      res  = modify(opnd, wd[7:6]);
      if (run && wd[0]) ma = res[15:0];
      if (run && wd[1]) mb = res[15:0];
      if (run && wd[2]) mx = res[15:0];
      if (ld) ma = sw;
      mof  = (mof && !clr) || (run && !wd[8] && res[16]);
      mexe = run || ld;
      @(negedge sys_clk);
   endtask
   // ==========================================
   // clock and watchdog
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   initial begin
      #400000;
      bad_count++;
      tally_and_finish();
   end
   // ==========================================
   // main sequence: word, switches, clear request
   initial begin
      corners = '{{16'h0F02, 16'h7FFF, 16'h0000}, {16'h0A49, 16'h1234, 16'h0000},
                  {16'h0B64, 16'h0000, 16'h0000}, {16'h0A12, 16'h0000, 16'h0001},
                  {16'h0BD2, 16'h0000, 16'h0000}, {16'h0AC9, 16'h0000, 16'h0000},
                  {16'h0BD2, 16'h0000, 16'h0000}, {16'h0A8F, 16'h0000, 16'h0000},
                  {16'h0A7B, 16'h0000, 16'h0000}, {16'h0A02, 16'h0000, 16'h0000},
                  {16'h0800, 16'h0000, 16'h0000}, {16'h0A48, 16'h0000, 16'h0000}};
      rst = 1'b1;
      overflow_clear = 1'b0;
      entry_switches = 16'h0000;
      {ma, mb, mx} = {3{RESET_WORD}};
      {mof, mexe} = 2'b00;
      seed = 32'hF45A;
      repeat (8) @(negedge sys_clk);
      rst = 1'b0;
      foreach (corners[i]) step(corners[i][47:32], 1'b1, corners[i][0], corners[i][31:16]);
      $display("corner cases done");
      repeat (300) begin
         seed = lfsr(seed);
         w = (seed[3:0] == 4'h0) ? seed[31:16] : {GROUP_CODE, seed[24:16]};
         step(w, seed[7] | seed[8], seed[5] & seed[6], seed[31:16]);
      end
      step(16'h0000, 1'b0, 1'b0, 16'h0000);
      $display("random run done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
